// *** pkg/bsctap_defines.svh ***
// constants of the boundary-scan test access port
// assumes inclusion by bare name from the package and the rtl files
// Operation
// R1 - five test signals: test clock, mode select, data in, data out, reset low
// R2 - reset low forces test-logic-reset at once, no test clock needed
// R3 - five rising test clock edges with mode high reach test-logic-reset
// R4 - in test-logic-reset logic is idle and identification instruction is loaded
// R5 - controller moves only on rising test clock, steered by sampled mode
// R6 - capture-data loads selected register; others keep their contents
// R7 - shift-data moves selected register toward lsb, data in at msb
// R8 - update-data loads output latches on falling test clock edge
// R9 - capture-instruction loads a fixed pattern into the instruction stage
// R10 - shift-instruction moves instruction stage toward lsb, lsb to data out
// R11 - instruction shifted in becomes current on falling edge in update-instruction
// R12 - pause states hold all register contents unchanged
// R13 - bypass puts one bit between data in and data out
// R14 - external test: boundary chain samples inputs, update drives outputs
// R15 - sample: boundary chain captures all input and output levels
// R16 - identification: fixed code shifts out during shift-data
// R17 - chain test: boundary chain captures the identification code
// R18 - identification code readable only through the serial port
// R19 - boundary chain has one cell per digital input and output
// R20 - three-bit instruction: 000 extest, 001 id, 010 sample, 101 chain, else bypass
// R21 - standard sixteen-state controller graph
// R22 - 32-bit identification register, lsb fixed at one
`ifndef BSCTAP_DEFINES_SVH
`define BSCTAP_DEFINES_SVH

`define BSCTAP_IR_W        3
`define BSCTAP_IR_EXTEST   3'h0
`define BSCTAP_IR_IDCODE   3'h1
`define BSCTAP_IR_SAMPLE   3'h2
`define BSCTAP_IR_CHAIN    3'h5
`define BSCTAP_IR_CAPTURE  3'h1
`define BSCTAP_ID_W        32
`define BSCTAP_BSR_LEN     636
`define BSCTAP_TLR_TMS_CNT 3'h5
`define BSCTAP_SYNC_W      3

`endif

// *** pkg/bsctap_pkg.sv ***
// types of the boundary-scan test access port
// assumes the defines header is on the include path
`include "bsctap_defines.svh"
package bsctap_pkg;

  // sixteen controller states
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SHIFT_DR, TAP_EXIT1_DR,
    TAP_PAUSE_DR, TAP_EXIT2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR,
    TAP_SHIFT_IR, TAP_EXIT1_IR, TAP_PAUSE_IR, TAP_EXIT2_IR, TAP_UPD_IR
  } bsctap_state_t;

  // serial path chosen by the current instruction
  typedef enum logic [1:0] {
    SEL_BSR, SEL_ID, SEL_BYP
  } bsctap_sel_t;

  // test pins sampled by the core clock
  typedef struct packed {
    logic tck;
    logic tms;
    logic tdi;
  } bsctap_pins_t;

  // serial output pin pair
  typedef struct packed {
    logic tdo;
    logic tdoEn;
  } bsctap_out_t;

endpackage : bsctap_pkg

// *** rtl/bsctap_pin_sync.sv ***
// three-stage synchroniser with agreement filter for the test pins
// assumes asynchronous pins and a free-running core clock
`timescale 1ns/1ps
`default_nettype none
`include "bsctap_defines.svh"
module bsctap_pin_sync (
  input  wire logic                      clk,
  input  wire logic                      rst,
  input  wire bsctap_pkg::bsctap_pins_t  pinsIn,
  output logic [`BSCTAP_SYNC_W-1:0]      pinsLvl
);

  logic [`BSCTAP_SYNC_W-1:0] s1_q;
  logic [`BSCTAP_SYNC_W-1:0] s2_q;
  logic [`BSCTAP_SYNC_W-1:0] s3_q;
  logic [`BSCTAP_SYNC_W-1:0] lvl_q;
  logic [`BSCTAP_SYNC_W-1:0] lvl_d;

  // a change counts only once stages two and three agree
  always_comb
  begin
    for (int i = 0; i < `BSCTAP_SYNC_W; i++)
    begin
      lvl_d[i] = (s2_q[i] == s3_q[i]) ? s3_q[i] : lvl_q[i];
    end
  end

  // stage one feeds only stage two
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      s1_q  <= '0;
      s2_q  <= '0;
      s3_q  <= '0;
      lvl_q <= '0;
    end
    else
    begin
      s1_q  <= pinsIn;
      s2_q  <= s1_q;
      s3_q  <= s2_q;
      lvl_q <= lvl_d;
    end
  end

  assign pinsLvl = lvl_q;

endmodule : bsctap_pin_sync
`default_nettype wire

// *** rtl/bsctap_top.sv ***
// test access port controller, instruction, bypass, id and boundary registers
// assumes test clock far slower than clk; pads and core levels wired by the chip
`timescale 1ns/1ps
`default_nettype none
`include "bsctap_defines.svh"
module bsctap_top #(
  parameter logic [`BSCTAP_ID_W-1:0] ID_CODE = 32'h0abc_d001  // arbitrary value, lsb one
) (
  input  wire logic                         clk,
  input  wire logic                         rst,
  input  wire bsctap_pkg::bsctap_pins_t     tapPins,
  input  wire logic                         trstN,
  input  wire logic [`BSCTAP_BSR_LEN-1:0]   pinLevels,
  input  wire logic [`BSCTAP_BSR_LEN-1:0]   coreOut,
  output bsctap_pkg::bsctap_out_t           tapOut,
  output logic [`BSCTAP_BSR_LEN-1:0]        padDrive,
  output logic                              extestActive
);

  logic [`BSCTAP_SYNC_W-1:0]     lvl;
  bsctap_pkg::bsctap_pins_t      lvlPins;
  logic                          tckLvl;
  logic                          tmsLvl;
  logic                          tdiLvl;
  logic                          tckPrev_q;
  logic                          tckRise;
  logic                          tckFall;
  logic                          tapRst;
  bsctap_pkg::bsctap_state_t     state_q;
  bsctap_pkg::bsctap_state_t     state_d;
  bsctap_pkg::bsctap_sel_t       sel;
  logic [`BSCTAP_IR_W-1:0]       irSh_q;
  logic [`BSCTAP_IR_W-1:0]       irSh_d;
  logic [`BSCTAP_IR_W-1:0]       irCur_q;
  logic [`BSCTAP_IR_W-1:0]       irCur_d;
  logic                          bypass_q;
  logic                          bypass_d;
  logic [`BSCTAP_ID_W-1:0]       idSh_q;
  logic [`BSCTAP_ID_W-1:0]       idSh_d;
  logic [`BSCTAP_BSR_LEN-1:0]    bsrSh_q;
  logic [`BSCTAP_BSR_LEN-1:0]    bsrSh_d;
  logic [`BSCTAP_BSR_LEN-1:0]    bsrUpd_q;
  logic [`BSCTAP_BSR_LEN-1:0]    bsrUpd_d;
  bsctap_pkg::bsctap_out_t       out_q;
  bsctap_pkg::bsctap_out_t       out_d;
  logic [`BSCTAP_BSR_LEN-1:0]    pad_q;
  logic [`BSCTAP_BSR_LEN-1:0]    pad_d;
  logic                          ext_q;
  logic                          ext_d;
  logic [2:0]                    tmsOnes_q;
  logic [2:0]                    tmsOnes_d;

  // R20 instruction decode
  function automatic bsctap_pkg::bsctap_sel_t decodeIr(input logic [`BSCTAP_IR_W-1:0] ir);
    case (ir)
      `BSCTAP_IR_EXTEST, `BSCTAP_IR_SAMPLE, `BSCTAP_IR_CHAIN: decodeIr = bsctap_pkg::SEL_BSR;
      `BSCTAP_IR_IDCODE:                                      decodeIr = bsctap_pkg::SEL_ID;
      default:                                                decodeIr = bsctap_pkg::SEL_BYP;
    endcase
  endfunction : decodeIr

  // R21 standard controller graph
  function automatic bsctap_pkg::bsctap_state_t nextState(input bsctap_pkg::bsctap_state_t s,
                                                          input logic tms);
    case (s)
      bsctap_pkg::TAP_RESET:    nextState = tms ? bsctap_pkg::TAP_RESET    : bsctap_pkg::TAP_IDLE;
      bsctap_pkg::TAP_IDLE:     nextState = tms ? bsctap_pkg::TAP_SEL_DR   : bsctap_pkg::TAP_IDLE;
      bsctap_pkg::TAP_SEL_DR:   nextState = tms ? bsctap_pkg::TAP_SEL_IR   : bsctap_pkg::TAP_CAP_DR;
      bsctap_pkg::TAP_CAP_DR:   nextState = tms ? bsctap_pkg::TAP_EXIT1_DR : bsctap_pkg::TAP_SHIFT_DR;
      bsctap_pkg::TAP_SHIFT_DR: nextState = tms ? bsctap_pkg::TAP_EXIT1_DR : bsctap_pkg::TAP_SHIFT_DR;
      bsctap_pkg::TAP_EXIT1_DR: nextState = tms ? bsctap_pkg::TAP_UPD_DR   : bsctap_pkg::TAP_PAUSE_DR;
      bsctap_pkg::TAP_PAUSE_DR: nextState = tms ? bsctap_pkg::TAP_EXIT2_DR : bsctap_pkg::TAP_PAUSE_DR;
      bsctap_pkg::TAP_EXIT2_DR: nextState = tms ? bsctap_pkg::TAP_UPD_DR   : bsctap_pkg::TAP_SHIFT_DR;
      bsctap_pkg::TAP_UPD_DR:   nextState = tms ? bsctap_pkg::TAP_SEL_DR   : bsctap_pkg::TAP_IDLE;
      bsctap_pkg::TAP_SEL_IR:   nextState = tms ? bsctap_pkg::TAP_RESET    : bsctap_pkg::TAP_CAP_IR;
      bsctap_pkg::TAP_CAP_IR:   nextState = tms ? bsctap_pkg::TAP_EXIT1_IR : bsctap_pkg::TAP_SHIFT_IR;
      bsctap_pkg::TAP_SHIFT_IR: nextState = tms ? bsctap_pkg::TAP_EXIT1_IR : bsctap_pkg::TAP_SHIFT_IR;
      bsctap_pkg::TAP_EXIT1_IR: nextState = tms ? bsctap_pkg::TAP_UPD_IR   : bsctap_pkg::TAP_PAUSE_IR;
      bsctap_pkg::TAP_PAUSE_IR: nextState = tms ? bsctap_pkg::TAP_EXIT2_IR : bsctap_pkg::TAP_PAUSE_IR;
      bsctap_pkg::TAP_EXIT2_IR: nextState = tms ? bsctap_pkg::TAP_UPD_IR   : bsctap_pkg::TAP_SHIFT_IR;
      bsctap_pkg::TAP_UPD_IR:   nextState = tms ? bsctap_pkg::TAP_SEL_DR   : bsctap_pkg::TAP_IDLE;
      default:                  nextState = bsctap_pkg::TAP_RESET;
    endcase
  endfunction : nextState

  // R1 test clock, mode and data pins cross into clk here
  bsctap_pin_sync u_sync (
    .clk     (clk),
    .rst     (rst),
    .pinsIn  (tapPins),
    .pinsLvl (lvl)
  );

  // filtered levels read back through the pin struct, no bare bit positions
  assign lvlPins = lvl;
  assign tckLvl  = lvlPins.tck;
  assign tmsLvl  = lvlPins.tms;
  assign tdiLvl  = lvlPins.tdi;
  assign tckRise = tckLvl & ~tckPrev_q;
  assign tckFall = ~tckLvl & tckPrev_q;
  // R2 reset pin acts as an asynchronous reset of the controller
  assign tapRst  = rst | ~trstN;
  assign sel     = decodeIr(irCur_q);

  // controller and all scan registers
  always_comb
  begin
    state_d  = state_q;
    irSh_d   = irSh_q;
    irCur_d  = irCur_q;
    bypass_d = bypass_q;
    idSh_d   = idSh_q;
    bsrSh_d  = bsrSh_q;
    bsrUpd_d = bsrUpd_q;
    out_d    = out_q;
    // R5 R3 moves only on rising test clock
    if (tckRise)
    begin
      state_d = nextState(state_q, tmsLvl);
      case (state_q)
        // R6 capture into the selected register only
        bsctap_pkg::TAP_CAP_DR:
        begin
          if (sel == bsctap_pkg::SEL_BYP)
          begin
            bypass_d = 1'b0;
          end
          else if (sel == bsctap_pkg::SEL_ID)
          begin
            // R16 R18 R22 fixed code loaded for shifting
            idSh_d = ID_CODE;
          end
          else if (irCur_q == `BSCTAP_IR_CHAIN)
          begin
            // R17 chain test captures the code, not pins
            bsrSh_d = {{(`BSCTAP_BSR_LEN-`BSCTAP_ID_W){1'b0}}, ID_CODE};
          end
          else
          begin
            // R14 R15 R19 every cell samples its pin level
            bsrSh_d = pinLevels;
          end
        end
        // R7 R13 shift toward lsb, data in at msb
        bsctap_pkg::TAP_SHIFT_DR:
        begin
          case (sel)
            bsctap_pkg::SEL_BYP: bypass_d = tdiLvl;
            bsctap_pkg::SEL_ID:  idSh_d   = {tdiLvl, idSh_q[`BSCTAP_ID_W-1:1]};
            default:             bsrSh_d  = {tdiLvl, bsrSh_q[`BSCTAP_BSR_LEN-1:1]};
          endcase
        end
        // R9 fixed pattern into instruction stage
        bsctap_pkg::TAP_CAP_IR:
        begin
          irSh_d = `BSCTAP_IR_CAPTURE;
        end
        // R10 instruction shift toward lsb
        bsctap_pkg::TAP_SHIFT_IR:
        begin
          irSh_d = {tdiLvl, irSh_q[`BSCTAP_IR_W-1:1]};
        end
        // R12 pause, exit and other states hold contents
        default:
        begin
          irSh_d = irSh_q;
        end
      endcase
    end
    // falling edge: update latches and data out
    if (tckFall)
    begin
      // R8 R14 update latches from the shift stage
      if (state_q == bsctap_pkg::TAP_UPD_DR && sel == bsctap_pkg::SEL_BSR)
      begin
        bsrUpd_d = bsrSh_q;
      end
      // R11 shifted instruction becomes current
      if (state_q == bsctap_pkg::TAP_UPD_IR)
      begin
        irCur_d = irSh_q;
      end
      // R7 R10 lsb of the active stage drives data out
      out_d.tdoEn = (state_q == bsctap_pkg::TAP_SHIFT_DR) || (state_q == bsctap_pkg::TAP_SHIFT_IR);
      if (state_q == bsctap_pkg::TAP_SHIFT_IR)
      begin
        out_d.tdo = irSh_q[0];
      end
      else
      begin
        case (sel)
          bsctap_pkg::SEL_BYP: out_d.tdo = bypass_q;
          bsctap_pkg::SEL_ID:  out_d.tdo = idSh_q[0];
          default:             out_d.tdo = bsrSh_q[0];
        endcase
      end
    end
    // R4 reset state holds the identification instruction
    if (state_q == bsctap_pkg::TAP_RESET)
    begin
      irCur_d = `BSCTAP_IR_IDCODE;
    end
  end

  // R2 reset pin low forces reset state without any clock
  always_ff @(posedge clk or posedge tapRst)
  begin
    if (tapRst)
    begin
      state_q   <= bsctap_pkg::TAP_RESET;
      irSh_q    <= `BSCTAP_IR_CAPTURE;
      irCur_q   <= `BSCTAP_IR_IDCODE;
      bypass_q  <= 1'b0;
      idSh_q    <= '0;
      bsrSh_q   <= '0;
      bsrUpd_q  <= '0;
      out_q     <= '0;
    end
    else
    begin
      state_q   <= state_d;
      irSh_q    <= irSh_d;
      irCur_q   <= irCur_d;
      bypass_q  <= bypass_d;
      idSh_q    <= idSh_d;
      bsrSh_q   <= bsrSh_d;
      bsrUpd_q  <= bsrUpd_d;
      out_q     <= out_d;
    end
  end

  // R4 R14 pads follow the core unless external test is current
  always_comb
  begin
    ext_d = (irCur_q == `BSCTAP_IR_EXTEST) && (state_q != bsctap_pkg::TAP_RESET);
    pad_d = ext_q ? bsrUpd_q : coreOut;
    // R3 helper count of consecutive high mode samples, saturating
    tmsOnes_d = tmsOnes_q;
    if (tckRise)
    begin
      tmsOnes_d = tmsLvl ? ((tmsOnes_q == `BSCTAP_TLR_TMS_CNT) ? tmsOnes_q : tmsOnes_q + 3'h1) : 3'h0;
    end
  end

  // pad mux registered so every output is a flop; costs one clk of latency
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      tckPrev_q <= 1'b0;
      ext_q     <= 1'b0;
      pad_q     <= '0;
      tmsOnes_q <= '0;
    end
    else
    begin
      tckPrev_q <= tckLvl;
      ext_q     <= ext_d;
      pad_q     <= pad_d;
      tmsOnes_q <= tmsOnes_d;
    end
  end

  assign tapOut       = out_q;
  assign padDrive     = pad_q;
  assign extestActive = ext_q;

  // R2 reset pin gives reset state next cycle
  property p_trst_reset;
    @(posedge clk) disable iff (rst) !trstN |=> (state_q == bsctap_pkg::TAP_RESET);
  endproperty
  a_trst_reset: assert property (p_trst_reset) else $error("reset pin did not reset controller"); // R2

  // R3 five high mode samples reach reset
  property p_tms_five;
    @(posedge clk) disable iff (tapRst) (tmsOnes_q == `BSCTAP_TLR_TMS_CNT) |-> (state_q == bsctap_pkg::TAP_RESET);
  endproperty
  a_tms_five: assert property (p_tms_five) else $error("five high mode edges missed reset"); // R3

  // R4 reset state loads identification instruction
  property p_ir_idcode;
    @(posedge clk) disable iff (tapRst) (state_q == bsctap_pkg::TAP_RESET) |=> (irCur_q == `BSCTAP_IR_IDCODE);
  endproperty
  a_ir_idcode: assert property (p_ir_idcode) else $error("instruction not id in reset"); // R4

  // R5 no move without a rising test clock
  property p_state_hold;
    @(posedge clk) disable iff (tapRst) !tckRise |=> $stable(state_q);
  endproperty
  a_state_hold: assert property (p_state_hold) else $error("state moved without test clock"); // R5

  // R13 bypass takes the data in level
  property p_bypass_shift;
    @(posedge clk) disable iff (tapRst)
      (tckRise && state_q == bsctap_pkg::TAP_SHIFT_DR && sel == bsctap_pkg::SEL_BYP) |=> (bypass_q == $past(tdiLvl));
  endproperty
  a_bypass_shift: assert property (p_bypass_shift) else $error("bypass bit not loaded"); // R13

  // R9 fixed instruction capture
  property p_capture_ir;
    @(posedge clk) disable iff (tapRst)
      (tckRise && state_q == bsctap_pkg::TAP_CAP_IR) |=> (irSh_q == `BSCTAP_IR_CAPTURE) ##1 (state_q != bsctap_pkg::TAP_CAP_IR);
  endproperty
  a_capture_ir: assert property (p_capture_ir) else $error("instruction capture wrong"); // R9

  // R11 update takes the shift stage
  property p_update_ir;
    @(posedge clk) disable iff (tapRst)
      (tckFall && state_q == bsctap_pkg::TAP_UPD_IR) |=> (irCur_q == $past(irSh_q));
  endproperty
  a_update_ir: assert property (p_update_ir) else $error("instruction update wrong"); // R11

  // R16 identification capture
  property p_id_capture;
    @(posedge clk) disable iff (tapRst)
      (tckRise && state_q == bsctap_pkg::TAP_CAP_DR && sel == bsctap_pkg::SEL_ID) |=> (idSh_q == ID_CODE);
  endproperty
  a_id_capture: assert property (p_id_capture) else $error("id code not captured"); // R16

endmodule : bsctap_top
`default_nettype wire

// *** testbench/bsctap_tester.sv ***
// external boundary-scan tester model: makes the test clock, steers mode and data, samples data out
// assumes one bench process calls its step task at a time, entering just after a clk edge
`timescale 1ns/1ps
`default_nettype none
`include "bsctap_defines.svh"
module bsctap_tester #(
  parameter int HALF_CLKS = 16  // 80 ns half period of the test clock at a 5 ns clk
) (
  input  wire logic                    clk,
  output var bsctap_pkg::bsctap_pins_t pins,
  input  wire logic                    tdo
);
  // test clock stands low between operations
  initial pins = '0;

  // half a test clock, landing just after a clk edge
  task automatic halfWait();
    repeat (HALF_CLKS) @(posedge clk);
    #1;
  endtask : halfWait

  // one cycle on the test link
  // data out is sampled just before the rising edge, the bit shown since the last fall
  task automatic step(input logic tms, input logic tdi, output logic tdoBit);
    pins.tms = tms;
    pins.tdi = tdi;
    halfWait();
    tdoBit = tdo;
    pins.tck = 1'h1;
    halfWait();
    pins.tck = 1'h0;
  endtask : step
endmodule : bsctap_tester
`default_nettype wire

// *** testbench/tb_bsctap_top.sv ***
// self-checking bench of the test access port, one task per scenario
// assumes the tester model in bsctap_tester.sv and the package compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "bsctap_defines.svh"
module tb_bsctap_top;
  localparam int          BL    = `BSCTAP_BSR_LEN;
  localparam logic [31:0] TB_ID = 32'h1234_5679;  // arbitrary value, lsb one

  logic                     clk;
  logic                     rst;
  logic                     trstN;
  bsctap_pkg::bsctap_pins_t tapPins;
  bsctap_pkg::bsctap_out_t  tapOut;
  logic [BL-1:0]            pinLevels;
  logic [BL-1:0]            coreOut;
  logic [BL-1:0]            padDrive;
  logic                     extestActive;
  int                       errCount;
  int                       totalChecks;

  bsctap_top #(.ID_CODE(TB_ID)) u_bsctap_top (
    .clk          (clk),
    .rst          (rst),
    .tapPins      (tapPins),
    .trstN        (trstN),
    .pinLevels    (pinLevels),
    .coreOut      (coreOut),
    .tapOut       (tapOut),
    .padDrive     (padDrive),
    .extestActive (extestActive)
  );

  bsctap_tester u_bsctap_tester (
    .clk  (clk),
    .pins (tapPins),
    .tdo  (tapOut.tdo)
  );

  // 200 MHz core clock
  initial
  begin
    clk = 1'h0;
    forever #2.5 clk = ~clk;
  end

  // verdict and counts, shared by the main sequence and the watchdog
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", totalChecks, errCount);
    if (errCount == 0 && totalChecks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // compare and count, reporting at once
  task automatic check(input logic [BL-1:0] got, input logic [BL-1:0] exp, input string what);
    totalChecks++;
    if (got !== exp)
    begin
      errCount++;
      $display("ERROR at %0t: %s", $time, what);
    end
  endtask : check

  // one test clock with data in low
  task automatic st(input logic tms);
    logic d;
    u_bsctap_tester.step(tms, 1'h0, d);
  endtask : st

  // shift a new instruction, then update makes it current
  task automatic loadIr(input logic [2:0] code);
    logic [2:0] outBits;
    logic       extBefore;
    extBefore = extestActive;
    st(1'h1); st(1'h1); st(1'h0); st(1'h0); // select-dr, select-ir, capture-ir, shift-ir
    for (int i = 0; i < 3; i++)
      u_bsctap_tester.step(i == 2, code[i], outBits[i]);
    check(outBits, `BSCTAP_IR_CAPTURE, "instruction capture pattern");
    check(extestActive, extBefore, "instruction took effect before update");
    st(1'h1); st(1'h0); // update-ir, idle
  endtask : loadIr

  // data scan from idle back to idle, optionally pausing before bit pauseAt
  task automatic shiftDr(input int n, input logic [BL-1:0] din, input int pauseAt, output logic [BL-1:0] dout);
    dout = '0;
    st(1'h1); st(1'h0); st(1'h0); // select-dr, capture-dr, shift-dr
    for (int i = 0; i < n; i++)
    begin
      if (pauseAt != 0 && i == pauseAt)
      begin
        st(1'h0); st(1'h0); st(1'h0); st(1'h1); st(1'h0); // pause, hold, hold, exit2, shift again
      end
      u_bsctap_tester.step(i == n - 1 || i == pauseAt - 1, din[i], dout[i]);
      if (i == 0)
        check(tapOut.tdoEn, 1'h1, "data out not driven in shift");
    end
    st(1'h1); st(1'h0); // update-dr, idle
  endtask : shiftDr

  // identification read, lsb first
  task automatic idCheck(input int pauseAt);
    logic [BL-1:0] d;
    shiftDr(32, '0, pauseAt, d);
    check(d[31:0], TB_ID, "identification code");
    check(d[0], 1'h1, "identification lsb");
  endtask : idCheck

  // after reset: normal operation and identification current, paused mid-read
  task automatic testResetId();
    check(extestActive, 1'h0, "test logic active after reset");
    check(padDrive, coreOut, "pads not from core after reset");
    st(1'h0);
    idCheck(16);
    $display("test reset_id done");
  endtask : testResetId

  // every bypass code gives a one-bit delay with captured zero first
  task automatic testBypass();
    logic [2:0]    codes [4];
    logic [BL-1:0] d;
    codes = '{3'h3, 3'h4, 3'h6, 3'h7};
    foreach (codes[k])
    begin
      loadIr(codes[k]);
      shiftDr(8, 8'hb2, 0, d);
      check(d[7:0], 8'h64, "bypass delay");
    end
    $display("test bypass done");
  endtask : testBypass

  // sample captures every pin level and leaves pads alone
  task automatic testSample();
    logic [BL-1:0] d;
    pinLevels = {159{4'h6}};
    loadIr(3'h2);
    shiftDr(BL, '0, 0, d);
    check(d, {159{4'h6}}, "sample capture");
    check(padDrive, coreOut, "sample drove pads");
    $display("test sample done");
  endtask : testSample

  // chain test captures the identification code, upper cells zero
  task automatic testChain();
    logic [BL-1:0] d;
    loadIr(3'h5);
    shiftDr(36, '0, 0, d);
    check(d[35:0], {4'h0, TB_ID}, "chain capture");
    $display("test chain done");
  endtask : testChain

  // external test: capture inputs, shift a pattern, update drives pads, then five-high reset
  task automatic testExtest();
    logic [BL-1:0] d;
    pinLevels = {159{4'h9}};
    loadIr(3'h0);
    check(extestActive, 1'h1, "external test not current");
    shiftDr(BL, {159{4'h3}}, 0, d);
    check(d, {159{4'h9}}, "external test capture");
    repeat (8) @(posedge clk);
    #1;
    check(padDrive, {159{4'h3}}, "update latches not on pads");
    st(1'h1); st(1'h0); st(1'h0); // into shift-dr
    st(1'h1); st(1'h1); st(1'h1); st(1'h1); // exit1, update, select-dr, select-ir
    check(extestActive, 1'h1, "reset after four highs");
    st(1'h1);
    check(extestActive, 1'h0, "no reset after five highs");
    check(padDrive, coreOut, "pads not returned to core");
    st(1'h0);
    $display("test extest done");
  endtask : testExtest

  // test reset low acts with the test clock stopped
  task automatic testTrst();
    loadIr(3'h0);
    check(extestActive, 1'h1, "external test not current");
    trstN = 1'h0;
    repeat (4) @(posedge clk);
    #1;
    check(extestActive, 1'h0, "test reset ignored");
    trstN = 1'h1;
    st(1'h0);
    idCheck(0);
    $display("test trst done");
  endtask : testTrst

  // main sequence: reset held five clocks, then the scenarios
  initial
  begin
    errCount = 0;
    totalChecks = 0;
    rst = 1'h1;
    trstN = 1'h0;
    pinLevels = '0;
    coreOut = {159{4'hc}};
    repeat (5) @(posedge clk);
    #1;
    rst = 1'h0;
    trstN = 1'h1;
    repeat (4) @(posedge clk);
    #1;
    testResetId();
    testBypass();
    testSample();
    testChain();
    testExtest();
    testTrst();
    end_of_test();
  end

  // watchdog: the tests take about 250 us
  initial
  begin
    #450us;
    errCount++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : tb_bsctap_top
`default_nettype wire
